/* verilog/diag_config_and_self_test.sv */
// diagnostic configuration registers, field checks and self-test control
// What this block does
// - turns step select bit: 0 gives 180-degree steps, 1 gives 45-degree steps.
// - lock pattern 1100 refuses non-volatile writes, other writes still accepted.
// - lock pattern 0011 refuses non-volatile and shadow writes, permanently.
// - logic self-test runs at power-up only when its enable bit is 1.
// - transducer self-test runs at power-up only when its enable bit is 1.
// - both power-up self-tests run concurrently, about thirty milliseconds total.
// - self-test block bit ignores host self-test commands; otherwise command starts them.
// - hard-reset block bit ignores host hard-reset command; otherwise command resets.
// - high limit is code times 32 gauss; code zero disables the check.
// - low limit is code times 16 gauss; code zero disables the check.
// - factory limits: high code 100101 (1184 G), low code 001101 (208 G).
// - host may start either self-test by a keyed register write while that test is idle and the self-test block bit is 0.
// - any self-test failure sets the self-test fail flag.
// - transducer test drives test current, steps direction and elements, checks angle.
// - logic test loads 31 chains in parallel from a 31-bit LFSR.
// - chain outputs compact into a 31-bit MISR signature.
// - field above high limit sets high flag and general error flag.
// - field below low limit sets low flag and general error flag.
`timescale 1ns/1ps
`default_nettype none
module diag_config_and_self_test
	import diag_pkg::*;
#(
	parameter int          TEST_CYCLES  = SELFTEST_CYCLES,
	parameter logic [30:0] EXPECTED_SIG = 31'h12345678,
	parameter logic [11:0] ANGLE_TOL    = 12'h020
)(
	input  wire logic        ref_clk,
	input  wire logic        rst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [9:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [11:0] fieldMag,
	input  wire logic        fieldValid,
	input  wire logic [11:0] xdcrAngle,
	input  wire logic [30:0] scanOut,
	output logic             scanEnable,
	output logic      [30:0] scanIn,
	output logic             xdcrTestMode,
	output logic             xdcrCurrentDir,
	output logic      [1:0]  xdcrElementSel,
	output logic             turnsStepSelect,
	output logic             hardResetReq,
	output logic             nvWriteReq,
	output logic             highFieldFlag,
	output logic             lowFieldFlag,
	output logic             selftestFailFlag,
	output logic             generalErrorFlag
);

	localparam logic [19:0] STEP_CYCLES = 20'(TEST_CYCLES / XDCR_STEPS);

	typedef struct packed {
		logic [23:0] turnsCfg;
		logic [23:0] lockCfg;
		logic [23:0] userNv;
		logic [31:0] rdata;
		logic        slvErr;
		logic        pwrDone;
		lbState_t    lbState;
		xdState_t    xdState;
		logic [19:0] xdTimer;
		logic [2:0]  xdStep;
		logic        lbStart;
		logic        lbFail;
		logic        xdFail;
		logic        selftest_fail_flag;
		logic        hiFlag;
		logic        loFlag;
		logic        hardRst;
		logic        nvWr;
	} diagState_t;

	diagState_t s;
	diagState_t next_s;

	logic        lbDone;
	logic [30:0] signature;
	logic [3:0]  lockCode;
	logic [5:0]  hiLim;
	logic [5:0]  loLim;
	logic        nvLocked;
	logic        shadowLocked;
	logic [11:0] angleErr;

	assign lockCode     = s.lockCfg[LOCK_LSB +: 4];
	assign hiLim        = s.lockCfg[HI_LIM_LSB +: 6];
	assign loLim        = s.lockCfg[LO_LIM_LSB +: 6];
	assign nvLocked     = (lockCode == LOCK_NV_ONLY) || (lockCode == LOCK_ALL);
	assign shadowLocked = (lockCode == LOCK_ALL);
	assign angleErr     = xdcrAngle - {s.xdStep, 9'h000};

	////////////////////////////////////////////////////////////////////////
	// logic self-test engine
	lbist_engine #(
		.CYCLES(TEST_CYCLES)
	) u_lbist (
		.ref_clk   (ref_clk),
		.rst       (rst),
		.start     (s.lbStart),
		.scanOut   (scanOut),
		.scanEnable(scanEnable),
		.scanIn    (scanIn),
		.done      (lbDone),
		.signature (signature)
	);

	////////////////////////////////////////////////////////////////////////
	// next-state logic: bus, commands, self-tests, field checks
	always_comb begin
		logic        wrAcc;
		logic        goLb;
		logic        goXd;
		logic        keyOk;
		logic        lbBad;
		logic        xdBad;
		logic [11:0] absErr;
		wrAcc  = psel && penable && pwrite && !s.slvErr;
		goLb   = 1'b0;
		goXd   = 1'b0;
		keyOk  = pwdata[15:8] == CMD_KEY;
		lbBad  = 1'b0;
		xdBad  = 1'b0;
		absErr = angleErr[11] ? 12'(-angleErr) : angleErr;
		next_s = s;
		next_s.lbStart = 1'b0;
		next_s.hardRst = 1'b0;
		next_s.nvWr = 1'b0;

		// setup phase: latch read data and the error answer
		if (psel && !penable) begin
			next_s.slvErr = 1'b0;
			next_s.rdata = '0;
			if (paddr == {IDX_TURNS, 2'b00}) begin
				next_s.rdata = {8'h00, s.turnsCfg};
				next_s.slvErr = pwrite && shadowLocked;
			end else if (paddr == {IDX_LOCKCFG, 2'b00}) begin
				next_s.rdata = {8'h00, s.lockCfg};
				next_s.slvErr = pwrite && shadowLocked;
			end else if (paddr == {IDX_USERNV, 2'b00}) begin
				next_s.rdata = {8'h00, s.userNv};
				next_s.slvErr = pwrite && shadowLocked;
			end else if (paddr == {IDX_CTRL, 2'b00}) begin
				next_s.rdata = '0;
			end else if (paddr == {IDX_STATUS, 2'b00}) begin
				next_s.rdata = {24'h000000, s.xdFail, s.lbFail, generalErrorFlag,
					s.loFlag, s.hiFlag, s.selftest_fail_flag, s.xdState == XD_RUN, s.lbState == LB_RUN};
			end else if (paddr == {IDX_SIG, 2'b00}) begin
				next_s.rdata = {1'b0, signature};
			end else begin
				next_s.slvErr = 1'b1;
			end
		end

		// access phase writes
		if (wrAcc) begin
			if (paddr == {IDX_TURNS, 2'b00}) begin
				next_s.turnsCfg = pwdata[23:0];
			end else if (paddr == {IDX_LOCKCFG, 2'b00}) begin
				next_s.lockCfg = pwdata[23:0];
			end else if (paddr == {IDX_USERNV, 2'b00}) begin
				next_s.userNv = pwdata[23:0];
			end else if (paddr == {IDX_CTRL, 2'b00} && keyOk) begin
				if (!s.lockCfg[ST_BLOCK_BIT]) begin
					goLb = pwdata[CMD_LBIST_BIT];
					goXd = pwdata[CMD_XDCR_BIT];
				end
				next_s.hardRst = pwdata[CMD_HRST_BIT] && !s.lockCfg[HR_BLOCK_BIT];
				next_s.nvWr = pwdata[CMD_NVWR_BIT] && !nvLocked;
			end else if (paddr == {IDX_STATUS, 2'b00} && pwdata[STAT_STF_BIT]) begin
				next_s.selftest_fail_flag = 1'b0;
			end
		end

		// power-up: one launch right after reset, both tests together
		if (!s.pwrDone) begin
			next_s.pwrDone = 1'b1;
			goLb = s.lockCfg[LBIST_EN_BIT];
			goXd = s.lockCfg[XDCR_EN_BIT];
		end

		// logic self-test sequencing
		case (s.lbState)
			LB_IDLE: begin
				if (goLb) begin
					next_s.lbState = LB_RUN;
					next_s.lbStart = 1'b1;
					next_s.lbFail = 1'b0;
				end
			end
			LB_RUN: begin
				if (lbDone) begin
					next_s.lbState = LB_IDLE;
					lbBad = signature != EXPECTED_SIG;
					next_s.lbFail = lbBad;
				end
			end
			default: next_s.lbState = LB_IDLE;
		endcase

		// transducer self-test: eight emulated field directions
		case (s.xdState)
			XD_IDLE: begin
				if (goXd) begin
					next_s.xdState = XD_RUN;
					next_s.xdTimer = '0;
					next_s.xdStep = '0;
					next_s.xdFail = 1'b0;
				end
			end
			XD_RUN: begin
				next_s.xdTimer = s.xdTimer + 20'h00001;
				if (s.xdTimer == STEP_CYCLES - 20'h00001) begin
					next_s.xdTimer = '0;
					next_s.xdStep = s.xdStep + 3'h1;
					if (absErr > ANGLE_TOL) begin
						xdBad = 1'b1;
						next_s.xdFail = 1'b1;
					end
					if (s.xdStep == 3'(XDCR_STEPS - 1)) begin
						next_s.xdState = XD_IDLE;
					end
				end
			end
			default: next_s.xdState = XD_IDLE;
		endcase

		// failure flag: a new failure wins over a clear in the same cycle
		if (lbBad || xdBad) begin
			next_s.selftest_fail_flag = 1'b1;
		end

		// field magnitude checks on each new sample
		if (fieldValid) begin
			next_s.hiFlag = (hiLim != 6'h00) && (fieldMag > {1'b0, hiLim, 5'h00});
			next_s.loFlag = (loLim != 6'h00) && (fieldMag < {2'h0, loLim, 4'h0});
		end
	end

	////////////////////////////////////////////////////////////////////////
	// state register
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			s <= '0;
			s.turnsCfg <= RST_TURNS;
			s.lockCfg <= RST_LOCKCFG;
			s.userNv <= RST_USERNV;
		end else begin
			s <= next_s;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs
	assign prdata           = s.rdata;
	assign pready           = 1'b1;
	assign pslverr          = psel && penable && s.slvErr;
	assign turnsStepSelect  = s.turnsCfg[TURNS_STEP_BIT];
	assign xdcrTestMode     = s.xdState == XD_RUN;
	assign xdcrCurrentDir   = s.xdStep[2];
	assign xdcrElementSel   = s.xdStep[1:0];
	assign hardResetReq     = s.hardRst;
	assign nvWriteReq       = s.nvWr;
	assign highFieldFlag    = s.hiFlag;
	assign lowFieldFlag     = s.loFlag;
	assign selftestFailFlag = s.selftest_fail_flag;
	assign generalErrorFlag = s.hiFlag || s.loFlag || s.selftest_fail_flag;

	////////////////////////////////////////////////////////////////////////
	// checks
	property p_turns_step;
		@(posedge ref_clk) disable iff (rst) psel && penable && pwrite && !pslverr
			&& paddr == {IDX_TURNS, 2'b00} |=> turnsStepSelect == $past(pwdata[TURNS_STEP_BIT]);
	endproperty
	a_turns_step: assert property (p_turns_step) else $error("turns step bit mismatch");
	property p_nv_lock;
		@(posedge ref_clk) disable iff (rst) nvLocked |=> !nvWriteReq;
	endproperty
	a_nv_lock: assert property (p_nv_lock) else $error("nv write while locked");
	property p_shadow_lock;
		@(posedge ref_clk) disable iff (rst) shadowLocked |=> $stable(s.lockCfg) && $stable(s.turnsCfg) && $stable(s.userNv);
	endproperty
	a_shadow_lock: assert property (p_shadow_lock) else $error("shadow changed while locked");
	property p_powerup_both;
		@(posedge ref_clk) disable iff (rst) !s.pwrDone && s.lockCfg[19] && s.lockCfg[18] |=> (s.lbState == LB_RUN) && (s.xdState == XD_RUN);
	endproperty
	a_powerup_both: assert property (p_powerup_both) else $error("power-up tests not concurrent");
	property p_powerup_lb_skip;
		@(posedge ref_clk) disable iff (rst) !s.pwrDone && !s.lockCfg[19] && s.lbState == LB_IDLE |=> s.lbState == LB_IDLE;
	endproperty
	a_powerup_lb_skip: assert property (p_powerup_lb_skip) else $error("logic test ran while disabled");
	property p_powerup_xd_skip;
		@(posedge ref_clk) disable iff (rst) !s.pwrDone && !s.lockCfg[18] && s.xdState == XD_IDLE |=> s.xdState == XD_IDLE;
	endproperty
	a_powerup_xd_skip: assert property (p_powerup_xd_skip) else $error("transducer test ran while disabled");
	property p_st_block;
		@(posedge ref_clk) disable iff (rst) s.pwrDone && s.lockCfg[13] && s.lbState == LB_IDLE |=> s.lbState == LB_IDLE;
	endproperty
	a_st_block: assert property (p_st_block) else $error("blocked self-test started");
	property p_hr_block;
		@(posedge ref_clk) disable iff (rst) s.lockCfg[12] |=> !hardResetReq;
	endproperty
	a_hr_block: assert property (p_hr_block) else $error("blocked hard reset issued");
	property p_hi_off;
		@(posedge ref_clk) disable iff (rst) fieldValid && hiLim == 6'h00 |=> !highFieldFlag;
	endproperty
	a_hi_off: assert property (p_hi_off) else $error("high flag with check disabled");
	property p_lo_off;
		@(posedge ref_clk) disable iff (rst) fieldValid && loLim == 6'h00 |=> !lowFieldFlag;
	endproperty
	a_lo_off: assert property (p_lo_off) else $error("low flag with check disabled");
	property p_lb_fail;
		@(posedge ref_clk) disable iff (rst) lbDone && s.lbState == LB_RUN && signature != EXPECTED_SIG |=> selftestFailFlag && s.lbFail;
	endproperty
	a_lb_fail: assert property (p_lb_fail) else $error("bad signature not flagged");
	property p_ef;
		@(posedge ref_clk) disable iff (rst) fieldValid && ((hiLim != 6'h00 && fieldMag > {1'b0, hiLim, 5'h00})
			|| (loLim != 6'h00 && fieldMag < {2'h0, loLim, 4'h0})) |=> generalErrorFlag;
	endproperty
	a_ef: assert property (p_ef) else $error("field out of limits without general error");

	c_powerup: cover property (@(posedge ref_clk) disable iff (rst) s.lbState == LB_RUN && s.xdState == XD_RUN);
	c_stf: cover property (@(posedge ref_clk) disable iff (rst) $rose(selftestFailFlag));
	c_hi: cover property (@(posedge ref_clk) disable iff (rst) $rose(highFieldFlag));
	c_nvwr: cover property (@(posedge ref_clk) disable iff (rst) nvWriteReq);

endmodule
`default_nettype wire

/* verilog/diag_pkg.sv */
// shared constants and types for the diagnostic configuration and self-test block
package diag_pkg;

	// register indices; the byte address is four times the index
	localparam logic [7:0] IDX_TURNS   = 8'h1d;
	localparam logic [7:0] IDX_LOCKCFG = 8'h1e;
	localparam logic [7:0] IDX_USERNV  = 8'h1f;
	localparam logic [7:0] IDX_CTRL    = 8'h30;
	localparam logic [7:0] IDX_STATUS  = 8'h31;
	localparam logic [7:0] IDX_SIG     = 8'h32;

	// reset values of the configuration shadow
	localparam logic [23:0] RST_TURNS   = 24'h80b29f;
	localparam logic [23:0] RST_LOCKCFG = 24'h0c094d;
	localparam logic [23:0] RST_USERNV  = 24'h000000;

	// field positions
	localparam int TURNS_STEP_BIT = 23;
	localparam int LOCK_LSB       = 20;
	localparam int LBIST_EN_BIT   = 19;
	localparam int XDCR_EN_BIT    = 18;
	localparam int ST_BLOCK_BIT   = 13;
	localparam int HR_BLOCK_BIT   = 12;
	localparam int HI_LIM_LSB     = 6;
	localparam int LO_LIM_LSB     = 0;
	localparam logic [3:0] LOCK_NV_ONLY = 4'hc;
	localparam logic [3:0] LOCK_ALL     = 4'h3;

	// control command word: key in [15:8], command bits below
	localparam logic [7:0] CMD_KEY  = 8'h5a;
	localparam int CMD_LBIST_BIT    = 0;
	localparam int CMD_XDCR_BIT     = 1;
	localparam int CMD_HRST_BIT     = 2;
	localparam int CMD_NVWR_BIT     = 3;
	localparam int STAT_STF_BIT     = 2;

	// self-test duration
	localparam int CLK_MHZ          = 25;
	localparam int SELFTEST_TIME_US = 30000;
	localparam int SELFTEST_CYCLES  = SELFTEST_TIME_US * CLK_MHZ;
	localparam int XDCR_STEPS       = 8;

	// pattern generator and compactor seeds
	localparam logic [30:0] LFSR_SEED = 31'h00000001;
	localparam logic [30:0] MISR_SEED = 31'h00000000;

	typedef enum logic [0:0] {LB_IDLE, LB_RUN} lbState_t;
	typedef enum logic [0:0] {XD_IDLE, XD_RUN} xdState_t;

endpackage

/* verilog/lbist_engine.sv */
// scan pattern generator and signature compactor for the logic self-test
`timescale 1ns/1ps
`default_nettype none
module lbist_engine
	import diag_pkg::*;
#(
	parameter int CYCLES = SELFTEST_CYCLES
)(
	input  wire logic        ref_clk,
	input  wire logic        rst,
	input  wire logic        start,
	input  wire logic [30:0] scanOut,
	output logic             scanEnable,
	output logic      [30:0] scanIn,
	output logic             done,
	output logic      [30:0] signature
);

	typedef struct packed {
		logic        run;
		logic        done;
		logic [19:0] cnt;
		logic [30:0] lfsr;
		logic [30:0] misr;
	} engState_t;

	engState_t s;
	engState_t next_s;

	////////////////////////////////////////////////////////////////////////
	// shift pattern into all chains in parallel, compact their outputs
	always_comb begin
		next_s = s;
		next_s.done = 1'b0;
		if (start && !s.run) begin
			next_s.run = 1'b1;
			next_s.cnt = '0;
			next_s.lfsr = LFSR_SEED;
			next_s.misr = MISR_SEED;
		end else if (s.run) begin
			next_s.lfsr = {s.lfsr[29:0], s.lfsr[30] ^ s.lfsr[27]};
			next_s.misr = {s.misr[29:0], s.misr[30] ^ s.misr[27]} ^ scanOut;
			next_s.cnt = s.cnt + 20'h00001;
			if (s.cnt == 20'(CYCLES - 1)) begin
				next_s.run = 1'b0;
				next_s.done = 1'b1;
			end
		end
	end

	// state register
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			s <= '{run: 1'b0, done: 1'b0, cnt: 20'h00000, lfsr: LFSR_SEED, misr: MISR_SEED};
		end else begin
			s <= next_s;
		end
	end

	assign scanEnable = s.run;
	assign scanIn     = s.lfsr;
	assign done       = s.done;
	assign signature  = s.misr;

endmodule
`default_nettype wire

/* verif/diag_far_side.sv */
// scan chain and transducer stand-in facing the self-test block
`timescale 1ns/1ps
`default_nettype none
module diag_far_side (
	input  wire logic        ref_clk,
	input  wire logic        scanEnable,
	input  wire logic [30:0] scanIn,
	input  wire logic        xdcrTestMode,
	input  wire logic        xdcrCurrentDir,
	input  wire logic [1:0]  xdcrElementSel,
	input  wire logic        badAngle,
	output logic      [30:0] scanOut,
	output logic      [11:0] xdcrAngle
);
	logic [30:0] chainReg  = 31'h00000000;
	logic [11:0] idleAngle = 12'h000;
	logic [11:0] skew;
	// chains hand the pattern on rotated; idle chains and idle angle keep changing
	always @(posedge ref_clk) begin
		chainReg <= scanEnable ? {scanIn[29:0], scanIn[30]} : ~chainReg;
		idleAngle <= idleAngle + 12'h3a7;
	end
	assign scanOut = chainReg;
	// one eighth turn per step, skewed by a quarter turn on command
	assign skew = badAngle ? 12'h400 : 12'h000;
	assign xdcrAngle = xdcrTestMode ? {xdcrCurrentDir, xdcrElementSel, 9'h000} + skew
		: idleAngle;
endmodule
`default_nettype wire

/* verif/diag_config_and_self_test_bench.sv */
// register, field check and self-test sequences for the diagnostic block
`timescale 1ns/1ps
`default_nettype none
module diag_config_and_self_test_bench
	import diag_pkg::*;
;
	localparam int TC = 64;
	localparam logic [11:0] FM [4] = '{12'h4a1, 12'h4a0, 12'h0cf, 12'h0d0};
	localparam logic [3:0]  FH     = 4'b0001;
	localparam logic [3:0]  FL     = 4'b0100;
	logic        ref_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
	logic [9:0]  paddr = 10'h000;
	logic [31:0] pwdata = 32'h00000000, prdata, rdata;
	logic        pready, pslverr, rerr, fieldValid = 0, badAngle = 0;
	logic [11:0] fieldMag = 12'h000, xdcrAngle;
	logic [30:0] scanOut, scanIn;
	logic        scanEnable, xdcrTestMode, xdcrCurrentDir, turnsStepSelect;
	logic [1:0]  xdcrElementSel;
	logic        hardResetReq, nvWriteReq, highFieldFlag, lowFieldFlag;
	logic        selftestFailFlag, generalErrorFlag;
	int          mismatches = 0, num_checks = 0, hrCount = 0, nvCount = 0;
	int          scanCycles = 0, xdcrCycles = 0, bothCycles = 0;

	always #20 ref_clk = ~ref_clk;

	diag_config_and_self_test #(.TEST_CYCLES(TC)) DUT (.ref_clk(ref_clk), .rst(rst),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .fieldMag(fieldMag),
		.fieldValid(fieldValid), .xdcrAngle(xdcrAngle), .scanOut(scanOut),
		.scanEnable(scanEnable), .scanIn(scanIn), .xdcrTestMode(xdcrTestMode),
		.xdcrCurrentDir(xdcrCurrentDir), .xdcrElementSel(xdcrElementSel),
		.turnsStepSelect(turnsStepSelect), .hardResetReq(hardResetReq),
		.nvWriteReq(nvWriteReq), .highFieldFlag(highFieldFlag), .lowFieldFlag(lowFieldFlag),
		.selftestFailFlag(selftestFailFlag), .generalErrorFlag(generalErrorFlag));

	diag_far_side FAR (.ref_clk(ref_clk), .scanEnable(scanEnable), .scanIn(scanIn),
		.xdcrTestMode(xdcrTestMode), .xdcrCurrentDir(xdcrCurrentDir),
		.xdcrElementSel(xdcrElementSel), .badAngle(badAngle), .scanOut(scanOut),
		.xdcrAngle(xdcrAngle));

	////////////////////////////////////////////////////////////////////////////////
	// pulse and activity counters
	always @(posedge ref_clk) begin
		if (hardResetReq === 1'b1) hrCount++;
		if (nvWriteReq === 1'b1) nvCount++;
		if (scanEnable === 1'b1) scanCycles++;
		if (xdcrTestMode === 1'b1) xdcrCycles++;
		if (scanEnable === 1'b1 && xdcrTestMode === 1'b1) bothCycles++;
	end

	////////////////////////////////////////////////////////////////////////////////
	// reporting
	task summarize;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task chkv(input logic [31:0] got, input logic [31:0] exp, input string m);
		num_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected at %0t: %s got %h want %h", $time, m, got, exp);
		end
	endtask
	task chkb(input logic got, input logic exp, input string m);
		num_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected at %0t: %s got %b want %b", $time, m, got, exp);
		end
	endtask
	task hang(input string m);
		mismatches++;
		$display("unexpected at %0t: %s", $time, m);
		summarize;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// apb master: setup, then access held until pready at a rising edge
	task apb(input logic wr, input logic [9:0] a, input logic [31:0] d);
		int n;
		@(posedge ref_clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) hang("no ready");
		rdata = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task wr(input logic [9:0] a, input logic [31:0] d, input logic e);
		apb(1'b1, a, d);
		chkb(rerr, e, "write error");
	endtask
	task rd(input logic [9:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h00000000);
		chkv(rdata, exp, "read data");
		chkb(rerr, 1'b0, "read error");
	endtask
	task settle;
		repeat (2) @(posedge ref_clk);
	endtask
	// tests start two edges after launch, so poll only after that
	task idle;
		int i;
		repeat (4) @(posedge ref_clk);
		for (i = 0; i < 40; i++) begin
			apb(1'b0, 10'h0c4, 32'h00000000);
			if (rdata[1:0] === 2'b00) break;
		end
		if (i == 40) hang("self-test never ends");
	endtask
	task field(input logic [11:0] mag, input logic hi, input logic lo);
		@(posedge ref_clk);
		fieldMag <= mag;
		fieldValid <= 1'b1;
		@(posedge ref_clk);
		fieldValid <= 1'b0;
		@(posedge ref_clk);
		chkb(highFieldFlag, hi, "high flag");
		chkb(lowFieldFlag, lo, "low flag");
		chkb(generalErrorFlag, hi | lo, "error flag");
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		repeat (12) @(posedge ref_clk);
		rst <= 1'b0;
		idle;
		chkv(scanCycles, TC, "scan cycles");
		chkv(xdcrCycles, TC, "test mode cycles");
		// the scan engine takes up its start one edge after the transducer test begins
		chkv(bothCycles, TC - 1, "overlap cycles");
		chkb(rdata[6], 1'b1, "signature fail");
		chkb(rdata[7], 1'b0, "transducer fail");
		chkb(selftestFailFlag, 1'b1, "fail flag");
		$display("test powerup done");
		rd(10'h074, 32'h0080b29f);
		chkb(turnsStepSelect, 1'b1, "step select");
		rd(10'h078, 32'h000c094d);
		rd(10'h07c, 32'h00000000);
		wr(10'h0c4, 32'h00000004, 1'b0);
		settle;
		chkb(selftestFailFlag, 1'b0, "fail flag cleared");
		wr(10'h074, 32'h00000000, 1'b0);
		settle;
		chkb(turnsStepSelect, 1'b0, "step select");
		wr(10'h074, 32'h00800000, 1'b0);
		settle;
		chkb(turnsStepSelect, 1'b1, "step select");
		apb(1'b0, 10'h3fc, 32'h00000000);
		chkv(rdata, 32'h00000000, "unmapped data");
		chkb(rerr, 1'b1, "unmapped error");
		wr(10'h3fc, 32'h00000001, 1'b1);
		$display("test registers done");
		for (int i = 0; i < 4; i++) field(FM[i], FH[i], FL[i]);
		wr(10'h078, 32'h000c0000, 1'b0);
		field(12'hfff, 1'b0, 1'b0);
		field(12'h000, 1'b0, 1'b0);
		$display("test field done");
		wr(10'h0c0, 32'h00005a04, 1'b0);
		wr(10'h0c0, 32'h00000004, 1'b0);
		settle;
		chkv(hrCount, 1, "hard reset count");
		wr(10'h078, 32'h000c1000, 1'b0);
		wr(10'h0c0, 32'h00005a04, 1'b0);
		settle;
		chkv(hrCount, 1, "blocked hard reset");
		wr(10'h078, 32'h000c2000, 1'b0);
		wr(10'h0c0, 32'h00005a03, 1'b0);
		apb(1'b0, 10'h0c4, 32'h00000000);
		chkv({30'h0, rdata[1:0]}, 32'h00000000, "blocked start");
		wr(10'h078, 32'h000c0000, 1'b0);
		badAngle <= 1'b1;
		wr(10'h0c0, 32'h00005a02, 1'b0);
		apb(1'b0, 10'h0c4, 32'h00000000);
		chkb(rdata[1], 1'b1, "host start");
		idle;
		chkb(rdata[7], 1'b1, "transducer fail");
		chkb(selftestFailFlag, 1'b1, "fail flag");
		badAngle <= 1'b0;
		$display("test control done");
		wr(10'h0c0, 32'h00005a08, 1'b0);
		settle;
		chkv(nvCount, 1, "commit");
		wr(10'h078, 32'h00cc0000, 1'b0);
		wr(10'h0c0, 32'h00005a08, 1'b0);
		wr(10'h07c, 32'h00123456, 1'b0);
		settle;
		chkv(nvCount, 1, "locked commit");
		rd(10'h07c, 32'h00123456);
		wr(10'h078, 32'h003c0000, 1'b0);
		wr(10'h07c, 32'h00000000, 1'b1);
		rd(10'h07c, 32'h00123456);
		wr(10'h078, 32'h00000000, 1'b1);
		rd(10'h078, 32'h003c0000);
		wr(10'h0c0, 32'h00005a08, 1'b0);
		settle;
		chkv(nvCount, 1, "full lock commit");
		$display("test lock done");
		summarize;
	end
endmodule
`default_nettype wire
